// >>> ops_stage.sv
// ops_stage: single-stage overpower protection with events, counters and records.
// Assumes sample_i marks each 5 ms program cycle; block_i comes from the blocking
// matrix and time_ms_i is a free-running millisecond clock.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Eight parameter sets, one common selector
// - Timestamped on/off events for three outputs
// - Instant mode: start and trip share stamp
// - Time stamps resolve one millisecond
// - Clearable counters for start, trip, blocked
// - Input is three-phase power every 5 ms
// - Pre-trigger uses 20 ms averaged power
// - Static setting picks current measurement side
// - Force state overrides status when enabled
// - Pick up when power exceeds threshold
// - Release below 97 percent of threshold
// - Start only while blocking is inactive
// - Blocking input sampled each cycle start
// - Blocked at pick-up: flag, no timing
// - Blocking drops start, release as normal
// - Blocking gives notification and power event
// - Trip after fixed definite delay
// - Status: condition, times, ratio readable
// - Mask selects on/off events reported
// - Twelve-entry circular on-event record
// - Record holds times, powers, group
module ops_stage
    import ops_pkg::*;
(
    input  wire logic            mclk_i,
    input  wire logic            reset_i,
    input  wire logic            sample_i,
    input  wire logic [PW-1:0]   power_a_i,
    input  wire logic [PW-1:0]   power_b_i,
    input  wire logic            measured_side_i,
    input  wire logic [GW-1:0]   setting_group_i,
    input  wire logic            cfg_wr_i,
    input  wire logic [GW-1:0]   cfg_group_i,
    input  wire logic [PW-1:0]   cfg_threshold_i,
    input  wire logic [TW-1:0]   cfg_delay_i,
    input  wire logic            cfg_instant_i,
    input  wire logic            block_i,
    input  wire logic            force_enable_i,
    input  wire logic [1:0]      forced_state_select_i,
    input  wire logic [TSW-1:0]  time_ms_i,
    input  wire logic [NOUT-1:0] ev_on_mask_i,
    input  wire logic [NOUT-1:0] ev_off_mask_i,
    input  wire logic [NOUT-1:0] cnt_clear_i,
    input  wire logic [3:0]      rec_index_i,
    output logic                 start_o,
    output logic                 trip_o,
    output logic                 blocked_o,
    output logic [1:0]           condition_o,
    output logic [TW-1:0]        expected_time_o,
    output logic signed [TW:0]   time_remaining_o,
    output logic [RW-1:0]        ratio_o,
    output logic                 event_valid_o,
    output logic [2:0]           event_id_o,
    output logic [TSW-1:0]       event_time_o,
    output logic [PW-1:0]        event_power_o,
    output logic                 notify_o,
    output logic [CW-1:0]        cnt_start_o,
    output logic [CW-1:0]        cnt_trip_o,
    output logic [CW-1:0]        cnt_block_o,
    output logic [3:0]           rec_count_o,
    output logic [TSW-1:0]       rec_time_o,
    output logic [2:0]           rec_id_o,
    output logic [PW-1:0]        rec_pre_trig_o,
    output logic [PW-1:0]        rec_fault_o,
    output logic [PW-1:0]        rec_pre_fault_o,
    output logic [TW-1:0]        rec_remaining_o,
    output logic [GW-1:0]        rec_group_o
);
    // Setting groups
    logic [PW-1:0] thr_q [NGRP];
    logic [TW-1:0] dly_q [NGRP];
    logic [NGRP-1:0] inst_q;
    // Input stage
    logic [PW-1:0] pwr_q, pwr_d, pwr_sel;
    logic          blk_q, blk_d, step_q;
    logic [GW-1:0] grp_q, grp_d;
    logic [PW-1:0] pre_trig, pre_fault;
    // Processing
    ops_state_t    state_q, state_d;
    logic [TW-1:0] timer_q, timer_d;
    logic          pick_q, pick_d;
    logic [TW-1:0] exp_q, exp_d, rem_q, rem_d;
    logic [RW-1:0] ratio_q, ratio_d;
    logic [PW-1:0] thr;
    logic [TW-1:0] dly;
    logic          above, below;
    logic [PW+7:0] pwr_pct, thr_pct;
    logic [PW+7:0] quot;
    // Outputs and events
    logic [NOUT-1:0] out_q, out_d, rise, fall;
    logic [1:0]      cond_q, cond_d;
    logic [NEV-1:0]  pend_q, pend_d;
    logic            fire;
    logic [2:0]      fire_id;
    logic            evv_q, evv_d, ntf_q, ntf_d;
    logic [2:0]      evid_q, evid_d;
    logic [TSW-1:0]  evt_q, evt_d, snt_q, snt_d;
    logic [PW-1:0]   evp_q, evp_d, snp_q, snp_d, sn20_q, sn20_d, sn200_q, sn200_d;
    logic [TW-1:0]   snr_q, snr_d;
    logic [GW-1:0]   sng_q, sng_d;
    logic [CW-1:0]   cnt_q [NOUT];
    logic [CW-1:0]   cnt_d [NOUT];
    // Record store
    logic [TSW-1:0]  rt_q [REC_N];
    logic [2:0]      ri_q [REC_N];
    logic [PW-1:0]   r20_q [REC_N];
    logic [PW-1:0]   rfp_q [REC_N];
    logic [PW-1:0]   r200_q [REC_N];
    logic [TW-1:0]   rrm_q [REC_N];
    logic [GW-1:0]   rg_q [REC_N];
    logic [3:0]      wp_q, wp_d, rcnt_q, rcnt_d, rd_idx;
    logic            rec_we;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            for (int g = 0; g < NGRP; g++) begin
                thr_q[g] <= THR_RST;
                dly_q[g] <= DLY_RST;
            end
            inst_q <= '0;
        end else if (cfg_wr_i) begin
            thr_q[cfg_group_i]  <= cfg_threshold_i;
            dly_q[cfg_group_i]  <= cfg_delay_i;
            inst_q[cfg_group_i] <= cfg_instant_i;
        end
    end

    // Input stage: power, blocking and active group are frozen at cycle start
    assign pwr_sel = measured_side_i ? power_b_i : power_a_i;
    always_comb begin
        pwr_d = sample_i ? pwr_sel : pwr_q;
        blk_d = sample_i ? block_i : blk_q;
        grp_d = sample_i ? setting_group_i : grp_q;
    end
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pwr_q  <= '0;
            blk_q  <= 1'b0;
            grp_q  <= '0;
            step_q <= 1'b0;
        end else begin
            pwr_q  <= pwr_d;
            blk_q  <= blk_d;
            grp_q  <= grp_d;
            step_q <= sample_i;
        end
    end

    ops_hist u_hist (
        .mclk_i   (mclk_i),
        .reset_i  (reset_i),
        .sample_i (sample_i),
        .power_i  (pwr_sel),
        .avg_o    (pre_trig),
        .old_o    (pre_fault)
    );

    // Processing, once per program cycle
    always_comb begin
        thr     = thr_q[grp_q];
        dly     = inst_q[grp_q] ? '0 : dly_q[grp_q];
        pwr_pct = (PW+8)'(pwr_q) * (PW+8)'(FULL_PCT);
        thr_pct = (PW+8)'(thr) * (PW+8)'(RESET_PCT);
        above   = pwr_q > thr;
        below   = pwr_pct < thr_pct;
        quot    = (thr == '0) ? (PW+8)'(RATIO_MAX) : pwr_pct / (PW+8)'(thr);
        state_d = state_q;
        timer_d = timer_q;
        pick_d  = pick_q;
        exp_d   = exp_q;
        rem_d   = rem_q;
        ratio_d = ratio_q;
        if (step_q) begin
            pick_d  = pick_q ? !below : above;
            exp_d   = dly;
            ratio_d = (quot > (PW+8)'(RATIO_MAX)) ? RATIO_MAX : RW'(quot);
            case (state_q)
                OPS_NORMAL: begin
                    timer_d = '0;
                    if (pick_d && blk_q) begin
                        state_d = OPS_BLOCKED;
                    end else if (pick_d) begin
                        state_d = (dly == '0) ? OPS_TRIP : OPS_START;
                    end
                end
                OPS_START: begin
                    if (!pick_d || blk_q) begin
                        timer_d = '0;
                        state_d = (pick_d && blk_q) ? OPS_BLOCKED : OPS_NORMAL;
                    end else if (timer_q + 1'b1 >= dly) begin
                        timer_d = dly;
                        state_d = OPS_TRIP;
                    end else begin
                        timer_d = timer_q + 1'b1;
                    end
                end
                OPS_TRIP: begin
                    if (!pick_d) begin
                        state_d = OPS_NORMAL;
                        timer_d = '0;
                    end else if (blk_q) begin
                        state_d = OPS_BLOCKED;
                        timer_d = '0;
                    end
                end
                default: begin
                    if (!pick_d || !blk_q) begin
                        state_d = OPS_NORMAL;
                    end
                end
            endcase
            rem_d = (state_d == OPS_TRIP) ? '0 : dly - timer_d;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= OPS_NORMAL;
            timer_q <= '0;
            pick_q  <= 1'b0;
            exp_q   <= DLY_RST;
            rem_q   <= DLY_RST;
            ratio_q <= '0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            pick_q  <= pick_d;
            exp_q   <= exp_d;
            rem_q   <= rem_d;
            ratio_q <= ratio_d;
        end
    end

    // Output flags; forcing bypasses the state machine without disturbing it
    always_comb begin
        cond_d = COND_NORMAL;
        if (force_enable_i) begin
            cond_d = forced_state_select_i;
        end else begin
            case (state_q)
                OPS_START: cond_d = COND_START;
                OPS_TRIP:  cond_d = COND_TRIP;
                OPS_BLOCKED: cond_d = COND_BLOCKED;
                default:   cond_d = COND_NORMAL;
            endcase
        end
        out_d[0] = (cond_d == COND_START) || (cond_d == COND_TRIP);
        out_d[1] = cond_d == COND_TRIP;
        out_d[2] = cond_d == COND_BLOCKED;
        rise = out_d & ~out_q;
        fall = ~out_d & out_q;
    end

    // Event sequencer: changes in one cycle share one snapshot and time stamp
    always_comb begin
        fire    = |pend_q;
        fire_id = '0;
        for (int e = NEV - 1; e >= 0; e--) begin
            if (pend_q[e]) begin
                fire_id = 3'(e);
            end
        end
        pend_d = pend_q;
        if (fire) begin
            pend_d[fire_id] = 1'b0;
        end
        for (int i = 0; i < NOUT; i++) begin
            pend_d[2*i]   = pend_d[2*i] | rise[i];
            pend_d[2*i+1] = pend_d[2*i+1] | fall[i];
        end
        snt_d   = snt_q;
        snp_d   = snp_q;
        sn20_d  = sn20_q;
        sn200_d = sn200_q;
        snr_d   = snr_q;
        sng_d   = sng_q;
        if (|(rise | fall)) begin
            snt_d   = time_ms_i;
            snp_d   = pwr_q;
            sn20_d  = pre_trig;
            sn200_d = pre_fault;
            snr_d   = rem_q;
            sng_d   = grp_q;
        end
        evv_d = fire && (fire_id[0] ? ev_off_mask_i[fire_id[2:1]] : ev_on_mask_i[fire_id[2:1]]);
        evid_d = fire ? fire_id : evid_q;
        evt_d  = fire ? snt_q : evt_q;
        evp_d  = fire ? snp_q : evp_q;
        ntf_d  = rise[2];
        for (int i = 0; i < NOUT; i++) begin
            // A count that lands with a clear survives as one
            cnt_d[i] = cnt_clear_i[i] ? CW'(rise[i]) : cnt_q[i] + CW'(rise[i]);
        end
    end
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            out_q   <= '0;
            cond_q  <= COND_NORMAL;
            pend_q  <= '0;
            evv_q   <= 1'b0;
            evid_q  <= '0;
            evt_q   <= '0;
            evp_q   <= '0;
            ntf_q   <= 1'b0;
            snt_q   <= '0;
            snp_q   <= '0;
            sn20_q  <= '0;
            sn200_q <= '0;
            snr_q   <= '0;
            sng_q   <= '0;
            for (int i = 0; i < NOUT; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            out_q   <= out_d;
            cond_q  <= cond_d;
            pend_q  <= pend_d;
            evv_q   <= evv_d;
            evid_q  <= evid_d;
            evt_q   <= evt_d;
            evp_q   <= evp_d;
            ntf_q   <= ntf_d;
            snt_q   <= snt_d;
            snp_q   <= snp_d;
            sn20_q  <= sn20_d;
            sn200_q <= sn200_d;
            snr_q   <= snr_d;
            sng_q   <= sng_d;
            cnt_q   <= cnt_d;
        end
    end

    // Record store: every ON event is kept, whatever the event mask says
    always_comb begin
        rec_we = fire && !fire_id[0];
        wp_d   = wp_q;
        rcnt_d = rcnt_q;
        if (rec_we) begin
            wp_d   = (wp_q == 4'(REC_N - 1)) ? 4'h0 : wp_q + 4'h1;
            rcnt_d = (rcnt_q == 4'(REC_N)) ? rcnt_q : rcnt_q + 4'h1;
        end
        rd_idx = 4'((int'(wp_q) + 2 * REC_N - 1 - int'(rec_index_i)) % REC_N);
    end
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wp_q   <= '0;
            rcnt_q <= '0;
        end else begin
            wp_q   <= wp_d;
            rcnt_q <= rcnt_d;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rec_we) begin
            rt_q[wp_q]   <= snt_q;
            ri_q[wp_q]   <= fire_id;
            r20_q[wp_q]  <= sn20_q;
            rfp_q[wp_q]  <= snp_q;
            r200_q[wp_q] <= sn200_q;
            rrm_q[wp_q]  <= snr_q;
            rg_q[wp_q]   <= sng_q;
        end
        if (reset_i) begin
            rec_time_o <= '0;
            rec_id_o <= '0;
            rec_pre_trig_o <= '0;
            rec_fault_o <= '0;
            rec_pre_fault_o <= '0;
            rec_remaining_o <= '0;
            rec_group_o <= '0;
        end else begin
            rec_time_o <= rt_q[rd_idx];
            rec_id_o <= ri_q[rd_idx];
            rec_pre_trig_o <= r20_q[rd_idx];
            rec_fault_o <= rfp_q[rd_idx];
            rec_pre_fault_o <= r200_q[rd_idx];
            rec_remaining_o <= rrm_q[rd_idx];
            rec_group_o <= rg_q[rd_idx];
        end
    end

    assign start_o = out_q[0];
    assign trip_o = out_q[1];
    assign blocked_o = out_q[2];
    assign condition_o = cond_q;
    assign expected_time_o = exp_q;
    assign time_remaining_o = {1'b0, rem_q};
    assign ratio_o = ratio_q;
    assign event_valid_o = evv_q;
    assign event_id_o = evid_q;
    assign event_time_o = evt_q;
    assign event_power_o = evp_q;
    assign notify_o = ntf_q;
    assign cnt_start_o = cnt_q[0];
    assign cnt_trip_o = cnt_q[1];
    assign cnt_block_o = cnt_q[2];
    assign rec_count_o = rcnt_q;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_idle_pick;
        step_q && state_q == OPS_NORMAL && !pick_q && above;
    endsequence
    property p_pickup;
        s_idle_pick |=> pick_q;
    endproperty
    a_pickup: assert property (p_pickup) else $error("pick-up missed");
    property p_hold;
        step_q && pick_q && !below |=> pick_q;
    endproperty
    a_hold: assert property (p_hold) else $error("released above reset level");
    property p_block_pick;
        s_idle_pick and blk_q |=> state_q == OPS_BLOCKED ##1 blocked_o || force_enable_i;
    endproperty
    a_block_pick: assert property (p_block_pick) else $error("blocked not taken");
    property p_start_free;
        s_idle_pick and !blk_q |=> state_q inside {OPS_START, OPS_TRIP};
    endproperty
    a_start_free: assert property (p_start_free) else $error("start not taken");
    property p_instant;
        s_idle_pick and !blk_q and inst_q[grp_q] |=> state_q == OPS_TRIP;
    endproperty
    a_instant: assert property (p_instant) else $error("instant trip late");
    property p_drop;
        step_q && state_q == OPS_START && blk_q |=> state_q != OPS_START && timer_q == '0;
    endproperty
    a_drop: assert property (p_drop) else $error("start kept under blocking");
    property p_dt;
        step_q && state_q == OPS_START && pick_d && !blk_q && timer_q + 1'b1 >= dly
            |=> state_q == OPS_TRIP;
    endproperty
    a_dt: assert property (p_dt) else $error("definite delay trip missed");
    property p_ev_start;
        $rose(start_o) |-> ##[0:6] (evid_q == EV_START_ON && $changed(evt_q) || pend_q == '0);
    endproperty
    a_ev_start: assert property (p_ev_start) else $error("start event lost");
    property p_force;
        force_enable_i |=> condition_o == $past(forced_state_select_i);
    endproperty
    a_force: assert property (p_force) else $error("forced state ignored");
    property p_clear;
        cnt_clear_i[0] && !rise[0] |=> cnt_start_o == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");
    property p_rec;
        rec_we && rcnt_q < 4'(REC_N) |=> rcnt_q == $past(rcnt_q) + 4'h1;
    endproperty
    a_rec: assert property (p_rec) else $error("record count stuck");
endmodule : ops_stage
`default_nettype wire

// >>> ops_pkg.sv
// ops_pkg: constants and types shared by the overpower protection stage.
// Assumes power samples arrive on a 5 ms strobe, scaled at 0.01 kW per LSB.
package ops_pkg;
    localparam int PW           = 28;  // Power width, 0.01 kW per LSB
    localparam int TW           = 19;  // Time width, 5 ms per LSB
    localparam int CW           = 16;  // Event counter width
    localparam int GW           = 3;   // Setting group index width
    localparam int TSW          = 32;  // Time stamp width, 1 ms per LSB
    localparam int RW           = 17;  // Ratio width, 0.01 per LSB
    localparam int NGRP         = 8;
    localparam int REC_N        = 12;
    localparam int NEV          = 6;
    localparam int NOUT         = 3;
    localparam int TIME_BASE_MS = 5;
    localparam int PRE_TRIG_MS  = 20;
    localparam int PRE_FAULT_MS = 200;
    localparam int AVG_N        = PRE_TRIG_MS / TIME_BASE_MS;
    localparam int HIST_N       = PRE_FAULT_MS / TIME_BASE_MS;
    localparam int RESET_PCT    = 97;
    localparam int FULL_PCT     = 100;

    localparam logic [RW-1:0] RATIO_MAX = 17'h1_E848;   // 1250.00
    localparam logic [PW-1:0] THR_RST   = 28'h000_2710; // 100 kW
    localparam logic [TW-1:0] DLY_RST   = 19'h0_0014;   // 100 ms

    localparam logic [1:0] COND_NORMAL  = 2'h0;
    localparam logic [1:0] COND_START   = 2'h1;
    localparam logic [1:0] COND_TRIP    = 2'h2;
    localparam logic [1:0] COND_BLOCKED = 2'h3;

    // Even codes are ON events, odd codes OFF events
    localparam logic [2:0] EV_START_ON  = 3'h0;
    localparam logic [2:0] EV_START_OFF = 3'h1;
    localparam logic [2:0] EV_TRIP_ON   = 3'h2;
    localparam logic [2:0] EV_TRIP_OFF  = 3'h3;
    localparam logic [2:0] EV_BLK_ON    = 3'h4;
    localparam logic [2:0] EV_BLK_OFF   = 3'h5;

    typedef enum logic [1:0] {
        OPS_NORMAL  = 2'h0,
        OPS_START   = 2'h1,
        OPS_TRIP    = 2'h3,
        OPS_BLOCKED = 2'h2
    } ops_state_t;
endpackage : ops_pkg

// >>> ops_hist.sv
// ops_hist: history of power samples for pre-trigger and pre-fault values.
// Assumes sample_i pulses once per 5 ms with power_i valid in that cycle.
`timescale 1ns/100ps
`default_nettype none
module ops_hist
    import ops_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    input  wire logic          sample_i,
    input  wire logic [PW-1:0] power_i,
    output var  logic [PW-1:0] avg_o,
    output var  logic [PW-1:0] old_o
);
    logic [PW-1:0] hist_q [HIST_N];
    logic [PW-1:0] hist_d [HIST_N];
    logic [5:0]    ptr_q;
    logic [5:0]    ptr_d;
    logic [PW+1:0] sum;
    logic [PW-1:0] avg_d;
    logic [PW-1:0] old_d;

    always_comb begin
        hist_d = hist_q;
        ptr_d  = ptr_q;
        sum    = '0;
        for (int k = 1; k <= AVG_N; k++) begin
            sum = sum + (PW+2)'(hist_q[(int'(ptr_q) + HIST_N - k) % HIST_N]);
        end
        avg_d = PW'(sum / AVG_N);
        // Slot under the pointer holds the sample 200 ms back only until this strobe overwrites it
        old_d = sample_i ? hist_q[ptr_q] : old_o;
        if (sample_i) begin
            hist_d[ptr_q] = power_i;
            ptr_d = (ptr_q == 6'(HIST_N - 1)) ? 6'h0 : ptr_q + 6'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            for (int k = 0; k < HIST_N; k++) begin
                hist_q[k] <= '0;
            end
            ptr_q <= '0;
            avg_o <= '0;
            old_o <= '0;
        end else begin
            hist_q <= hist_d;
            ptr_q  <= ptr_d;
            avg_o  <= avg_d;
            old_o  <= old_d;
        end
    end
endmodule : ops_hist
`default_nettype wire

// >>> ops_src.sv
// ops_src: program-cycle strobe and millisecond stamp feeding the stage.
// Assumes one clock; a strobe every 8 cycles stands in for the 5 ms time base.
`timescale 1ns/100ps
`default_nettype none
module ops_src (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    output var  logic        sample_o,
    output var  logic [31:0] time_ms_o
);
    logic [2:0] div_q;
    always_ff @(posedge mclk_i) begin
        div_q     <= reset_i ? 3'h0 : div_q + 3'h1;
        sample_o  <= !reset_i && div_q == 3'h7;
        // Each strobe advances the stamp by one 5 ms step at 1 ms resolution
        time_ms_o <= reset_i ? 32'h0000_0000 : time_ms_o + ((div_q == 3'h7) ? 32'h0000_0005 : 32'h0000_0000);
    end
endmodule : ops_src
`default_nettype wire

// >>> testbench.sv
// testbench: drives the overpower stage and compares it with an integer state model.
// Assumes ops_src supplies the program-cycle strobe and the millisecond stamp.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ops_pkg::*;
    logic               mclk_i, reset_i, sample_i, measured_side_i, cfg_wr_i, cfg_instant_i, block_i;
    logic               force_enable_i, start_o, trip_o, blocked_o, event_valid_o, notify_o;
    logic [PW-1:0]      power_a_i, power_b_i, cfg_threshold_i, event_power_o;
    logic [PW-1:0]      rec_pre_trig_o, rec_fault_o, rec_pre_fault_o;
    logic [GW-1:0]      setting_group_i, cfg_group_i, rec_group_o;
    logic [TW-1:0]      cfg_delay_i, expected_time_o, rec_remaining_o;
    logic [1:0]         forced_state_select_i, condition_o;
    logic [TSW-1:0]     time_ms_i, event_time_o, rec_time_o;
    logic [NOUT-1:0]    ev_on_mask_i, ev_off_mask_i, cnt_clear_i;
    logic [3:0]         rec_index_i, rec_count_o;
    logic signed [TW:0] time_remaining_o;
    logic [RW-1:0]      ratio_o;
    logic [2:0]         event_id_o, rec_id_o;
    logic [CW-1:0]      cnt_start_o, cnt_trip_o, cnt_block_o;
    logic [TSW-1:0]     ev_t [0:5];
    logic [31:0]        lfsr;
    int failures, check_count, st, tmr, thr, dly, inst, pu, cs, ct, cb, rec, nn, g;

    ops_src ops_src_inst (.mclk_i, .reset_i, .sample_o(sample_i), .time_ms_o(time_ms_i));
    ops_stage ops_stage_inst (.*);

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        if (event_valid_o === 1'b1) begin
            ev_t[event_id_o] <= event_time_o;
            chk("event_mask", 1'({ev_off_mask_i, ev_on_mask_i} >> (3 * event_id_o[0] + event_id_o[2:1])), 1);
        end
        if (notify_o === 1'b1) nn <= nn + 1;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", n, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic final_report;
        $display("Checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc

    task automatic cfg(input int gr, input int t, input int d, input int i);
        cfg_group_i = gr;
        cfg_threshold_i = t;
        cfg_delay_i = d;
        cfg_instant_i = i;
        cfg_wr_i = 1'b1;
        cyc(1);
        cfg_wr_i = 1'b0;
        setting_group_i = gr;
        thr = t;
        dly = d;
        inst = i;
        cyc(1);
    endtask : cfg

    // One program cycle: present the inputs, wait for the strobe, advance the model, compare
    task automatic step(input int p, input logic b);
        int k;
        int old;
        int rem;
        power_a_i = measured_side_i ? 28'h000_0000 : PW'(p);
        power_b_i = measured_side_i ? PW'(p) : 28'hfff_ffff;
        block_i = b;
        for (k = 0; k < 20 && sample_i !== 1'b1; k++) cyc(1);
        if (k == 20) begin
            failures++;
            final_report();
        end
        cyc(7);
        old = st;
        pu = pu ? (p * 100 >= thr * 97) : (p > thr);
        if (!pu) st = 0;
        else if (b) st = 3;
        else if (st == 3) st = 0;
        else if (st == 0) begin
            tmr = 0;
            st = (inst || dly == 0) ? 2 : 1;
        end else if (st == 1) begin
            tmr++;
            if (tmr >= dly) st = 2;
        end
        cs += (old == 0 || old == 3) && (st == 1 || st == 2);
        ct += old != 2 && st == 2;
        cb += old != 3 && st == 3;
        rec = (old == 0 || old == 3) && (st == 1 || st == 2) ? rec + 1 : rec;
        rec = old != 2 && st == 2 ? rec + 1 : rec;
        rec = old != 3 && st == 3 ? rec + 1 : rec;
        rem = (st == 2 || inst) ? 0 : (st == 1 ? dly - tmr : dly);
        chk("start", start_o, st == 1 || st == 2);
        chk("trip", trip_o, st == 2);
        chk("blocked", blocked_o, st == 3);
        chk("condition", condition_o, st);
        chk("expected_time", expected_time_o, inst ? 0 : dly);
        chk("cnt_start", cnt_start_o, cs);
        chk("cnt_trip", cnt_trip_o, ct);
        chk("cnt_block", cnt_block_o, cb);
        chk("rec_count", rec_count_o, rec > REC_N ? REC_N : rec);
        chk("ratio", ratio_o, p * 100 / thr);
        chk("remaining", time_remaining_o, rem);
        if (old != st) chk("event_power", event_power_o, p);
        if (old != st && st != 0) begin
            chk("rec_fault", rec_fault_o, p);
            chk("rec_id", rec_id_o, 2 * st - 2);
            chk("rec_remaining", rec_remaining_o, rem);
        end
    endtask : step

    initial begin
        {measured_side_i, cfg_wr_i, cfg_instant_i, block_i, force_enable_i} = 5'h00;
        {power_a_i, power_b_i, cfg_threshold_i, setting_group_i, cfg_group_i, cfg_delay_i} = '0;
        {forced_state_select_i, cnt_clear_i, rec_index_i} = '0;
        ev_on_mask_i = 3'h7;
        ev_off_mask_i = 3'h7;
        {failures, check_count, st, tmr, pu, cs, ct, cb, rec, nn} = '0;
        lfsr = 32'h1007_5fab;
        reset_i = 1'b1;
        cyc(12);
        reset_i = 1'b0;
        chk("expected_rst", expected_time_o, DLY_RST);
        chk("cond_rst", condition_o, 0);
        for (g = 0; g < NGRP; g++) cfg(g, 1000 * g + 1000, 40, 0);
        for (g = 0; g < NGRP; g++) begin
            setting_group_i = g;
            thr = 1000 * g + 1000;
            measured_side_i = g % 2;
            step(thr, 0);
            step(thr + 1, 0);
            step(0, 0);
        end
        cfg(0, 10000, 3, 0);
        step(10001, 0);
        step(9700, 0);
        step(9699, 0);
        for (g = 0; g < 4; g++) step(10001, 0);
        chk("trip_delay", ev_t[2] - ev_t[0], 5 * dly);
        step(10001, 1);
        step(10001, 1);
        step(10001, 0);
        step(10001, 0);
        step(0, 0);
        step(20000, 1);
        step(0, 0);
        cfg(4, 3000, 5, 1);
        step(4000, 0);
        chk("instant_stamp", ev_t[2] - ev_t[0], 0);
        step(0, 0);
        cfg(6, 5000, 2, 0);
        for (g = 0; g < 60; g++) begin
            lfsr = lfsr_next(lfsr);
            measured_side_i = lfsr[9];
            ev_off_mask_i = lfsr[2:0];
            step(lfsr[23:10] % 10000, lfsr[7:4] == 4'h0);
        end
        chk("notify_count", nn, cb);
        chk("rec_group", rec_group_o, 6);
        cnt_clear_i = 3'h7;
        cyc(2);
        cnt_clear_i = 3'h0;
        cyc(2);
        chk("cnt_cleared", {cnt_start_o, cnt_trip_o}, 0);
        chk("cnt_block_cleared", cnt_block_o, 0);
        force_enable_i = 1'b1;
        for (g = 0; g < 4; g++) begin
            forced_state_select_i = g;
            cyc(3);
            chk("forced", condition_o, g);
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
